// file: dtp_pkg.sv
// Shared constants for the dual 8-bit timer pair block
package dtp_pkg;
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RUN = 8'h20;
  localparam logic [IDX_W-1:0] IDX_DBUF = 8'h21;
  localparam logic [IDX_W-1:0] IDX_A_CMP_LO = 8'h22;
  localparam logic [IDX_W-1:0] IDX_A_CMP_HI = 8'h23;
  localparam logic [IDX_W-1:0] IDX_A_MODE = 8'h24;
  localparam logic [IDX_W-1:0] IDX_B_MODE = 8'h25;
  localparam logic [IDX_W-1:0] IDX_B_CMP_LO = 8'h26;
  localparam logic [IDX_W-1:0] IDX_B_CMP_HI = 8'h27;
  localparam logic [IDX_W-1:0] IDX_FLOP = 8'h28;
  localparam logic [IDX_W-1:0] IDX_STAT = 8'h29;

  // Mode register fields
  localparam int MODE_LCLK_LSB = 0;
  localparam int MODE_UCLK_LSB = 2;
  localparam int MODE_PAIR_LSB = 4;
  localparam int MODE_FSRC_BIT = 6;
  localparam logic [1:0] PM_8BIT = 2'h0;
  localparam logic [1:0] PM_16BIT = 2'h1;
  localparam logic [1:0] PM_PPG = 2'h2;
  localparam logic [1:0] LCLK_EXT = 2'h0;
  localparam logic [1:0] LCLK_T1 = 2'h1;
  localparam logic [1:0] LCLK_T4 = 2'h2;
  localparam logic [1:0] UCLK_LMATCH = 2'h0;
  localparam logic [1:0] UCLK_T1 = 2'h1;
  localparam logic [1:0] UCLK_T16 = 2'h2;

  // Flop control register fields and commands
  localparam int FLOP_A_CMD_LSB = 0;
  localparam int FLOP_A_INV_BIT = 2;
  localparam int FLOP_B_CMD_LSB = 4;
  localparam int FLOP_B_INV_BIT = 6;
  localparam logic [1:0] FC_INVERT = 2'h0;
  localparam logic [1:0] FC_SET = 2'h1;
  localparam logic [1:0] FC_CLEAR = 2'h2;
  localparam logic [1:0] FC_KEEP = 2'h3;

  // Run and double-buffer register bits
  localparam int RUN_A_LO = 0;
  localparam int RUN_A_UP = 1;
  localparam int RUN_B_LO = 2;
  localparam int RUN_B_UP = 3;
  localparam int RUN_PRESC = 7;
  localparam int DBUF_A = 0;
  localparam int DBUF_B = 1;

  // Prescaler taps: a tick when all masked bits are ones
  localparam int PRESC_W = 9;
  localparam logic [PRESC_W-1:0] TAP_T1 = 9'h001;
  localparam logic [PRESC_W-1:0] TAP_T4 = 9'h007;
  localparam logic [PRESC_W-1:0] TAP_T16 = 9'h01F;
  localparam logic [PRESC_W-1:0] TAP_T256 = 9'h1FF;

  // Reset value and counter increment
  localparam logic [CNT_W-1:0] REG8_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
endpackage

// file: dtp_top.sv
// Dual 8-bit timer pair with AXI4-Lite register slave
//
// What this block does
// RL1: 8-bit mode: counter equal to compare clears counter and pulses match irq.
// RL2: With inversion enabled, the pair flop toggles in the match cycle.
// RL3: Each pair owns one output flop, driven onto its wave pin.
// RL4: 8-bit mode: both timers run independently with own counter, compare, irq.
// RL5: 8-bit mode: upper timer may count lower timer match pulses.
// RL6: Flop command 00 inverts the pair flop regardless of counting.
// RL7: Flop command 10 clears, 01 sets the flop regardless of counting.
// RL8: Compare registers read back as zero; flop commands read back as 11, flop state hidden.
// RL9: Pair mode 01 cascades both timers into one 16-bit timer.
// RL10: 16-bit mode: upper counts lower overflow, its clock select ignored.
// RL11: 16-bit period is upper:lower compare; software writes lower first.
// RL12: Lower compare write suspends 16-bit match until upper compare write.
// RL13: 16-bit mode: lower match alone neither clears nor interrupts.
// RL14: 16-bit match of both halves clears both, upper irq, optional toggle.
// RL15: PROGRAMMABLE_PULSE_MODE mode: lower timer makes square wave; polarity from flop preset.
// RL16: PROGRAMMABLE_PULSE_MODE mode: upper timer held idle, its compare is the period.
// RL17: PROGRAMMABLE_PULSE_MODE with double buffer: buffer loads lower compare at each period.
// RL18: Each pair's PROGRAMMABLE_PULSE_MODE wave appears on its own wave pin.
// RL19: Compare value zero matches on counter overflow.
// RL20: Double buffer enable: clear writes both, set writes buffer only.
// RL21: Prescaler counts while its run bit is set, else cleared.
// RL22: Clearing a timer run bit stops and zeroes its counter.
// RL23: Each match interrupt is one single-cycle pulse per event.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dtp_pair #(
  parameter bit HAS_EXT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_t1,
  input wire logic tick_t4,
  input wire logic tick_t16,
  input wire logic tick_t256,
  input wire logic ext_tick,
  input wire logic [dtp_pkg::CNT_W-1:0] mode,
  input wire logic run_lo,
  input wire logic run_up,
  input wire logic inv_en,
  input wire logic dbuf_en,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [dtp_pkg::CNT_W-1:0] wdata,
  output logic [dtp_pkg::CNT_W-1:0] lo_cnt_reg,
  output logic [dtp_pkg::CNT_W-1:0] up_cnt_reg,
  output logic lo_irq_reg,
  output logic up_irq_reg,
  output logic flop_reg
);
  import dtp_pkg::*;

  logic [CNT_W-1:0] cmp_lo_reg;
  logic [CNT_W-1:0] cmp_hi_reg;
  logic [CNT_W-1:0] cmp_buf_reg;
  logic susp_reg;
  logic [1:0] pmode;
  logic [1:0] lclk;
  logic [1:0] uclk;
  logic is8;
  logic is16;
  logic isppg;
  logic lo_src;
  logic up_src;
  logic lo_tick;
  logic up_tick;
  logic [CNT_W-1:0] lo_next;
  logic [CNT_W-1:0] up_next;
  logic [CNT_W-1:0] up_after;
  logic lo_ovf;
  logic lo_match8;
  logic up_match8;
  logic match16;
  logic ppg_duty;
  logic ppg_period;
  logic toggle;

  assign pmode = mode[MODE_PAIR_LSB +: 2];
  assign lclk = mode[MODE_LCLK_LSB +: 2];
  assign uclk = mode[MODE_UCLK_LSB +: 2];
  // Unsupported mode 11 behaves as plain 8-bit timers
  assign is16 = (pmode == PM_16BIT);
  assign isppg = (pmode == PM_PPG);
  assign is8 = !is16 && !isppg;

  always_comb begin
    case (lclk)
      LCLK_EXT: lo_src = ext_tick && HAS_EXT;
      LCLK_T1: lo_src = tick_t1;
      LCLK_T4: lo_src = tick_t4;
      default: lo_src = tick_t16;
    endcase
  end

  assign lo_tick = run_lo && lo_src;
  assign lo_next = lo_cnt_reg + CNT_ONE;
  assign lo_ovf = lo_tick && (lo_next == REG8_RST);

  // Compare on the incremented value, so zero only hits at overflow
  assign lo_match8 = lo_tick && is8 && (lo_next == cmp_lo_reg); // RL1 RL19

  always_comb begin
    if (is16) begin
      up_src = lo_ovf; // RL10
    end else begin
      case (uclk)
        UCLK_LMATCH: up_src = lo_match8; // RL5
        UCLK_T1: up_src = tick_t1;
        UCLK_T16: up_src = tick_t16;
        default: up_src = tick_t256;
      endcase
    end
  end

  assign up_tick = run_up && up_src && !isppg; // RL16
  assign up_next = up_cnt_reg + CNT_ONE;
  assign up_after = up_tick ? up_next : up_cnt_reg;
  assign up_match8 = up_tick && is8 && (up_next == cmp_hi_reg); // RL4

  // Both halves must agree in the same tick; a suspended pair never fires
  assign match16 = lo_tick && is16 && !susp_reg &&
                   (lo_next == cmp_lo_reg) && (up_after == cmp_hi_reg); // RL14

  assign ppg_duty = lo_tick && isppg && (lo_next == cmp_lo_reg); // RL15
  assign ppg_period = lo_tick && isppg && (lo_next == cmp_hi_reg); // RL16

  always_comb begin
    toggle = 1'b0;
    if (isppg) begin
      toggle = ppg_duty ^ ppg_period; // RL15
    end else if (inv_en) begin
      if (is16) begin
        toggle = match16; // RL14
      end else begin
        toggle = mode[MODE_FSRC_BIT] ? up_match8 : lo_match8; // RL2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_cnt_reg <= REG8_RST;
    end else if (!run_lo) begin
      lo_cnt_reg <= REG8_RST; // RL22
    end else if (lo_tick) begin
      if (lo_match8 || match16 || ppg_period) begin
        lo_cnt_reg <= REG8_RST; // RL1
      end else begin
        lo_cnt_reg <= lo_next; // RL13
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_cnt_reg <= REG8_RST;
    end else if (!run_up || isppg) begin
      up_cnt_reg <= REG8_RST; // RL22
    end else if (match16) begin
      up_cnt_reg <= REG8_RST; // RL14
    end else if (up_tick) begin
      up_cnt_reg <= up_match8 ? REG8_RST : up_next; // RL4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_irq_reg <= 1'b0;
      up_irq_reg <= 1'b0;
    end else begin
      lo_irq_reg <= lo_match8 || ppg_period; // RL23 RL13
      up_irq_reg <= up_match8 || match16; // RL23 RL14
    end
  end

  // Software commands override a match toggle in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flop_reg <= 1'b0;
    end else if (cmd_valid && cmd != FC_KEEP) begin
      case (cmd)
        FC_INVERT: flop_reg <= !flop_reg; // RL6
        FC_SET: flop_reg <= 1'b1; // RL7
        FC_CLEAR: flop_reg <= 1'b0; // RL7
        default: flop_reg <= flop_reg;
      endcase
    end else if (toggle) begin
      flop_reg <= !flop_reg; // RL2
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_buf_reg <= REG8_RST;
    end else if (wr_lo) begin
      cmp_buf_reg <= wdata; // RL20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_lo_reg <= REG8_RST;
    end else if (wr_lo && !dbuf_en) begin
      cmp_lo_reg <= wdata; // RL20
    end else if (ppg_period && dbuf_en) begin
      cmp_lo_reg <= cmp_buf_reg; // RL17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_hi_reg <= REG8_RST;
    end else if (wr_hi) begin
      cmp_hi_reg <= wdata; // RL11
    end
  end

  // Half-written 16-bit period must not match against a stale upper byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_reg <= 1'b0;
    end else if (wr_lo) begin
      susp_reg <= 1'b1; // RL12
    end else if (wr_hi) begin
      susp_reg <= 1'b0; // RL12
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dtp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dtp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dtp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dtp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dtp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_input,
  output logic pair_a_wave_pin,
  output logic pair_b_wave_pin,
  output logic pair_a_lower_match_irq,
  output logic pair_a_upper_match_irq,
  output logic pair_b_lower_match_irq,
  output logic pair_b_upper_match_irq
);
  import dtp_pkg::*;

  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic w_strb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [CNT_W-1:0] run_control_reg;
  logic [CNT_W-1:0] dbuf_control_reg;
  logic [CNT_W-1:0] pair_a_mode_reg;
  logic [CNT_W-1:0] pair_b_mode_reg;
  logic [CNT_W-1:0] flop_control_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic ext_prev_reg;
  logic wr_fire;
  logic wr_en;
  logic wr_hit;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic [CNT_W-1:0] wbyte;
  logic [DATA_W-1:0] rd_mux;
  logic rd_hit;
  logic prescaler_run_bit;
  logic tick_t1;
  logic tick_t4;
  logic tick_t16;
  logic tick_t256;
  logic ext_tick;
  logic flop_wr;
  logic [CNT_W-1:0] a_lo_cnt;
  logic [CNT_W-1:0] a_up_cnt;
  logic [CNT_W-1:0] b_lo_cnt;
  logic [CNT_W-1:0] b_up_cnt;
  logic pair_a_out_flop;
  logic pair_b_out_flop;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken independently, answered together
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = aw_addr_reg[ADDR_W-1:IDX_LSB];
  assign wr_en = wr_fire && w_strb0_reg;
  assign wbyte = w_data_reg[CNT_W-1:0];

  always_comb begin
    case (wr_idx)
      IDX_RUN, IDX_DBUF, IDX_A_CMP_LO, IDX_A_CMP_HI, IDX_A_MODE,
      IDX_B_MODE, IDX_B_CMP_LO, IDX_B_CMP_HI, IDX_FLOP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb0_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  assign s_axi_arready = !rvalid_reg;
  assign rd_idx = s_axi_araddr[ADDR_W-1:IDX_LSB];

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_RUN: rd_mux[CNT_W-1:0] = run_control_reg;
      IDX_DBUF: rd_mux[CNT_W-1:0] = dbuf_control_reg;
      IDX_A_MODE: rd_mux[CNT_W-1:0] = pair_a_mode_reg;
      IDX_B_MODE: rd_mux[CNT_W-1:0] = pair_b_mode_reg;
      IDX_FLOP: begin
        // Commands read as no-op; flop state stays hidden
        rd_mux[FLOP_A_CMD_LSB +: 2] = FC_KEEP;
        rd_mux[FLOP_B_CMD_LSB +: 2] = FC_KEEP;
        rd_mux[FLOP_A_INV_BIT] = flop_control_reg[FLOP_A_INV_BIT];
        rd_mux[FLOP_B_INV_BIT] = flop_control_reg[FLOP_B_INV_BIT]; // RL8
      end
      IDX_STAT: rd_mux = {b_up_cnt, b_lo_cnt, a_up_cnt, a_lo_cnt};
      IDX_A_CMP_LO, IDX_A_CMP_HI, IDX_B_CMP_LO, IDX_B_CMP_HI: begin
        rd_mux = '0; // RL8
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_control_reg <= REG8_RST;
    end else if (wr_en && wr_idx == IDX_RUN) begin
      run_control_reg <= wbyte; // RL22
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbuf_control_reg <= REG8_RST;
    end else if (wr_en && wr_idx == IDX_DBUF) begin
      dbuf_control_reg <= wbyte; // RL20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_a_mode_reg <= REG8_RST;
      pair_b_mode_reg <= REG8_RST;
    end else if (wr_en && wr_idx == IDX_A_MODE) begin
      pair_a_mode_reg <= wbyte; // RL9
    end else if (wr_en && wr_idx == IDX_B_MODE) begin
      pair_b_mode_reg <= wbyte; // RL9
    end
  end

  assign flop_wr = wr_en && (wr_idx == IDX_FLOP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flop_control_reg <= REG8_RST;
    end else if (flop_wr) begin
      flop_control_reg <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler; stopping it also freezes every timer on internal clocks
  assign prescaler_run_bit = run_control_reg[RUN_PRESC];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= '0;
    end else if (!prescaler_run_bit) begin
      presc_reg <= '0; // RL21
    end else begin
      presc_reg <= presc_reg + PRESC_W'(1); // RL21
    end
  end

  assign tick_t1 = prescaler_run_bit && ((presc_reg & TAP_T1) == TAP_T1);
  assign tick_t4 = prescaler_run_bit && ((presc_reg & TAP_T4) == TAP_T4);
  assign tick_t16 = prescaler_run_bit && ((presc_reg & TAP_T16) == TAP_T16);
  assign tick_t256 = prescaler_run_bit &&
                     ((presc_reg & TAP_T256) == TAP_T256);

  // External count input counts rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_count_input;
    end
  end

  assign ext_tick = ext_count_input && !ext_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  dtp_pair #(.HAS_EXT(1'b1)) u_pair_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_t1(tick_t1),
    .tick_t4(tick_t4),
    .tick_t16(tick_t16),
    .tick_t256(tick_t256),
    .ext_tick(ext_tick),
    .mode(pair_a_mode_reg),
    .run_lo(run_control_reg[RUN_A_LO]),
    .run_up(run_control_reg[RUN_A_UP]),
    .inv_en(flop_control_reg[FLOP_A_INV_BIT]),
    .dbuf_en(dbuf_control_reg[DBUF_A]),
    .cmd_valid(flop_wr),
    .cmd(wbyte[FLOP_A_CMD_LSB +: 2]),
    .wr_lo(wr_en && wr_idx == IDX_A_CMP_LO),
    .wr_hi(wr_en && wr_idx == IDX_A_CMP_HI),
    .wdata(wbyte),
    .lo_cnt_reg(a_lo_cnt),
    .up_cnt_reg(a_up_cnt),
    .lo_irq_reg(pair_a_lower_match_irq),
    .up_irq_reg(pair_a_upper_match_irq),
    .flop_reg(pair_a_out_flop)
  );

  // Second pair has no external count input
  dtp_pair #(.HAS_EXT(1'b0)) u_pair_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_t1(tick_t1),
    .tick_t4(tick_t4),
    .tick_t16(tick_t16),
    .tick_t256(tick_t256),
    .ext_tick(1'b0),
    .mode(pair_b_mode_reg),
    .run_lo(run_control_reg[RUN_B_LO]),
    .run_up(run_control_reg[RUN_B_UP]),
    .inv_en(flop_control_reg[FLOP_B_INV_BIT]),
    .dbuf_en(dbuf_control_reg[DBUF_B]),
    .cmd_valid(flop_wr),
    .cmd(wbyte[FLOP_B_CMD_LSB +: 2]),
    .wr_lo(wr_en && wr_idx == IDX_B_CMP_LO),
    .wr_hi(wr_en && wr_idx == IDX_B_CMP_HI),
    .wdata(wbyte),
    .lo_cnt_reg(b_lo_cnt),
    .up_cnt_reg(b_up_cnt),
    .lo_irq_reg(pair_b_lower_match_irq),
    .up_irq_reg(pair_b_upper_match_irq),
    .flop_reg(pair_b_out_flop)
  );

  assign pair_a_wave_pin = pair_a_out_flop; // RL3 RL18
  assign pair_b_wave_pin = pair_b_out_flop; // RL3 RL18
endmodule

// file: dtp_monitor.sv
// Port checker for the dual timer pair
`timescale 1ns/1ps
module dtp_monitor
  import dtp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic pair_a_wave_pin,
  input wire logic pair_b_wave_pin,
  input wire logic pair_a_lower_match_irq,
  input wire logic pair_a_upper_match_irq,
  input wire logic pair_b_lower_match_irq,
  input wire logic pair_b_upper_match_irq
);
  wire [3:0] irqs = {pair_b_upper_match_irq, pair_b_lower_match_irq,
    pair_a_upper_match_irq, pair_a_lower_match_irq};
  wire [7:0] ridx = s_axi_araddr[9:2];
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire cmp_idx = ridx[7:1] == 7'h11 || ridx[7:1] == 7'h13;
  wire bad_idx = ridx < IDX_RUN || ridx > IDX_STAT;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset must win over any pending bus or timer state
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> irqs == 4'h0 && !s_axi_bvalid && !s_axi_rvalid
    && !pair_a_wave_pin && !pair_b_wave_pin)
    else $error("outputs not cleared by reset");
  a_irq_single: assert property (
    (irqs & $past(irqs)) == 4'h0) else $error("irq longer than one cycle");
  a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  a_read_lat: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_resp: assert property (wr_go && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_write_hold: assert property (wr_go |=> !s_axi_awready && !s_axi_wready)
    else $error("ready high while write held");
  a_cmp_hidden: assert property (ar_go && cmp_idx |=>
    s_axi_rdata == '0 && s_axi_rresp == RESP_OKAY)
    else $error("compare register readable");
  a_unmapped_err: assert property (ar_go && bad_idx |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  c_upper_irq: cover property (pair_a_upper_match_irq);
  c_ppg_period: cover property (pair_b_lower_match_irq);
  c_bad_read: cover property (ar_go && bad_idx);
endmodule

// file: dtp_ext_src.sv
// Pulse source standing in for the external count pin
`timescale 1ns/1ps
module dtp_ext_src (
  input wire logic aclk,
  input wire logic en,
  input wire logic [7:0] half,
  output logic ext_level
);
  logic [7:0] cnt_reg;
  // Idle low between bursts so no stray edge is counted
  always_ff @(posedge aclk) begin
    if (!en) begin
      cnt_reg <= 8'h00;
      ext_level <= 1'b0;
    end else if (cnt_reg == half - 8'h01) begin
      cnt_reg <= 8'h00;
      ext_level <= !ext_level;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// file: dtp_top_tb.sv
// Self-checking bench for the dual timer pair
`timescale 1ns/1ps
module dtp_top_tb;
  import dtp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, ext_en = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_count_input, pair_a_wave_pin, pair_b_wave_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pair_a_lower_match_irq, pair_a_upper_match_irq;
  logic pair_b_lower_match_irq, pair_b_upper_match_irq;
  int mismatches = 0, num_checks = 0, cyc = 0;
  wire [3:0] irq_v = {pair_b_upper_match_irq, pair_b_lower_match_irq,
    pair_a_upper_match_irq, pair_a_lower_match_irq};
  wire [1:0] pin_v = {pair_b_wave_pin, pair_a_wave_pin};

  dtp_top dut (.*);
  dtp_ext_src ext (.aclk(aclk), .en(ext_en), .half(8'h03),
    .ext_level(ext_count_input));

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
      input logic [1:0] er = RESP_OKAY);
    logic aw, w, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw && s_axi_awready;
      tw = w && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw = aw && !ta;
      w = w && !tw;
    end
    while (!s_axi_bvalid) @(negedge aclk);
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
      input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(negedge aclk);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask

  // Gap between two pulses of irq s, pin edges inside it, irq q silent
  task automatic gap(input int s, input int q, input int eg, input int ee);
    int k, e, nq;
    logic p;
    k = 0;
    e = 0;
    nq = 0;
    while (irq_v[s] !== 1'b1) @(negedge aclk);
    p = pin_v[s/2];
    do begin
      @(negedge aclk);
      k++;
      if (pin_v[s/2] !== p) e++;
      p = pin_v[s/2];
      if (irq_v[q] !== 1'b0) nq++;
    end while (irq_v[s] !== 1'b1);
    chk(k, eg);
    chk(e, ee);
    chk(nq, 0);
  endtask

  task automatic t_regs();
    rd(IDX_STAT, 32'h0);
    rd(IDX_A_CMP_LO, 32'h0);
    rd(IDX_FLOP, 32'h33);
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h2A, 8'hFF, RESP_SLVERR);
    // Byte lane 0 off: the write is answered but must change nothing
    s_axi_wstrb <= 4'hE;
    wr(IDX_RUN, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(IDX_RUN, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_flop();
    logic [1:0] c [4] = '{FC_SET, FC_INVERT, FC_INVERT, FC_CLEAR};
    logic [1:0] p [4] = '{2'h3, 2'h0, 2'h3, 2'h0};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_FLOP, {2'h0, c[i], 2'h0, c[i]});
      chk(pin_v, p[i]);
    end
    $display("test flop done");
  endtask

  task automatic t_eight();
    wr(IDX_FLOP, 8'h37);
    wr(IDX_A_MODE, 8'h01);
    wr(IDX_A_CMP_LO, 8'h03);
    wr(IDX_RUN, 8'h81);
    gap(0, 1, 6, 1);
    wr(IDX_A_CMP_LO, 8'h00);
    gap(0, 1, 512, 1);
    // Flop source on the upper timer, else lower matches toggle it instead
    wr(IDX_A_MODE, 8'h45);
    wr(IDX_A_CMP_LO, 8'h03);
    wr(IDX_A_CMP_HI, 8'h05);
    wr(IDX_RUN, 8'h83);
    gap(1, 3, 10, 1);
    wr(IDX_A_MODE, 8'h01);
    gap(1, 3, 30, 5);
    wr(IDX_RUN, 8'h80);
    rd(IDX_STAT, 32'h0);
    $display("test eight done");
  endtask

  task automatic t_sixteen();
    int n;
    n = 0;
    // Upper clock field set to T1 on purpose: cascade must ignore it
    wr(IDX_A_MODE, 8'h15);
    wr(IDX_A_CMP_LO, 8'h02);
    wr(IDX_A_CMP_HI, 8'h01);
    wr(IDX_RUN, 8'h83);
    gap(1, 0, 516, 1);
    wr(IDX_A_CMP_LO, 8'h02);
    repeat (1100) @(negedge aclk) if (irq_v[1] !== 1'b0) n++;
    chk(n, 0);
    $display("test sixteen done");
  endtask

  task automatic t_ppg();
    wr(IDX_B_MODE, 8'h21);
    wr(IDX_B_CMP_LO, 8'h02);
    wr(IDX_B_CMP_HI, 8'h08);
    wr(IDX_RUN, 8'h84);
    gap(2, 3, 16, 2);
    // Buffered duty equal to the period: both toggles cancel once loaded
    wr(IDX_DBUF, 8'h02);
    wr(IDX_B_CMP_LO, 8'h08);
    gap(2, 3, 16, 0);
    // Plain 8-bit mode never loads the buffer, so the period must hold
    wr(IDX_B_MODE, 8'h02);
    wr(IDX_B_CMP_LO, 8'h02);
    gap(2, 3, 64, 0);
    wr(IDX_DBUF, 8'h00);
    wr(IDX_B_CMP_LO, 8'h02);
    gap(2, 3, 16, 0);
    $display("test ppg done");
  endtask

  task automatic t_ext();
    wr(IDX_RUN, 8'h00);
    wr(IDX_A_MODE, 8'h00);
    wr(IDX_A_CMP_LO, 8'h04);
    ext_en <= 1'b1;
    wr(IDX_RUN, 8'h01);
    gap(0, 1, 24, 1);
    ext_en <= 1'b0;
    $display("test ext done");
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_flop();
    t_eight();
    t_sixteen();
    t_ppg();
    t_ext();
    conclude();
  end
endmodule

bind dtp_top dtp_monitor mon (.*);
